// >>> src/pm_map.vh
// offsets, fields, reset values and timing counts of the power sequencer
`ifndef PM_MAP_VH
`define PM_MAP_VH
`define PM_CLK_MHZ 40
`define PM_IRC_START_US 60
`define PM_IRC_START_CYC (`PM_IRC_START_US * `PM_CLK_MHZ)
`define PM_FLASH_START_US 100
`define PM_FLASH_START_CYC (`PM_FLASH_START_US * `PM_CLK_MHZ)
`define PM_IRC_RESUME_CYC 4
`define PM_OSC_RESUME_CYC 4096
`define PM_USB_HALF_CYC 1
`define PM_OFF_MODE 8'h00
`define PM_OFF_CLKOUT 8'h04
`define PM_OFF_DIV 8'h08
`define PM_OFF_PCLKEN 8'h0c
`define PM_OFF_PDIV 8'h10
`define PM_OFF_STATUS 8'h14
`define PM_REQ_LSB 0
`define PM_USBSYN_BIT 2
`define PM_OSCEN_BIT 3
`define PM_CPUMAIN_BIT 4
`define PM_MSYN_BIT 5
`define PM_MCON_BIT 6
`define PM_MODE_MASK 32'h0000007f
`define PM_MODE_RST 32'h00000000
`define PM_CLKOUT_RST 3'h0
`define PM_DIV_RST 8'h00
`define PM_PCLKEN_RST 32'hffffffff
`define PM_PDIV_RST 32'h00000000
`define PM_REQ_SLEEP 2'h0
`define PM_REQ_DSLEEP 2'h1
`define PM_REQ_PDOWN 2'h2
`define PM_CO_CPU 3'h0
`define PM_CO_IRC 3'h1
`define PM_CO_MAIN 3'h2
`define PM_CO_RTC 3'h3
`define PM_CO_USB 3'h4
`endif

// >>> src/power_mode_wake_sequencer.v
// power-mode, wake-up and clock gating sequencer with wishbone registers
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "pm_map.vh"
// Notes on behaviour
// (RULE1) usb synth off after reset; usb clock then from main synth 48 MHz
// (RULE2) usb synth reference only main oscillator; output goes only to usb
// (RULE3) usb synth output has equal high and low halves
// (RULE4) clock out selects cpu, rc, main crystal, rtc or usb clock
// (RULE5) run from 4 MHz rc at power-up and after power-down wake
// (RULE6) software enables and awaits a stable source before selecting it
// (RULE7) wake-up timer runs after reset and power-down wake before execution
// (RULE8) sleep gates only core clock; halted until reset or interrupt
// (RULE9) deep-sleep stops oscillator and clocks, keeps state, holds pins
// (RULE10) deep-sleep disables rc output, keeps rc powered, rtc runs
// (RULE11) deep-sleep entry disconnects main synth, clears cpu and usb dividers
// (RULE12) flash stays powered in deep-sleep; exit by reset or wake interrupt
// (RULE13) deep-sleep resume after 4 cycles on rc or 4096 on main oscillator
// (RULE14) power-down also removes power from rc and flash
// (RULE15) power-down wake: 60 us rc start-up, then 4 rc cycles
// (RULE16) flash blocked 100 us after power-down wake by flash counter
// (RULE17) deep power-down only from rtc; everything off but rtc and reset
// (RULE18) deep power-down left only by reset pin or rtc alarm
// (RULE19) interrupt controller hands enabled, high priority mask at entry
// (RULE20) masked interrupts watched while stopped; any one wakes the cpu
// (RULE21) per-peripheral clock switch-off and own clock divider
// (RULE22) software mode request and clock enables applied at low-power entry
module power_mode_wake_sequencer #(
  parameter NIRQ = 8,
  parameter NPER = 8,
  parameter [12:0] IRC_START = `PM_IRC_START_CYC,
  parameter [12:0] FLASH_START = `PM_FLASH_START_CYC,
  parameter [12:0] IRC_RESUME = `PM_IRC_RESUME_CYC,
  parameter [12:0] OSC_RESUME = `PM_OSC_RESUME_CYC
) (
  input wire sys_clk,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire cpuSleepReq,
  input wire [NIRQ-1:0] irqIn,
  input wire [NIRQ-1:0] wakeMaskIn,
  input wire rtcDpdReq,
  input wire rtcAlarm,
  input wire mainOscStable,
  input wire mainOscLvl,
  input wire rtcLvl,
  output reg cpuClkEn,
  output reg cpuRun,
  output reg [NPER-1:0] periphClkEn,
  output reg [NPER-1:0] periphTick,
  output reg ircPower,
  output reg ircOutEn,
  output reg rtcOscEn,
  output reg mainOscEn,
  output reg mainSynthEn,
  output reg mainSynthConnect,
  output reg usbSynthPower,
  output reg usbSynthRef,
  output reg usbFromSynth,
  output reg usbClk,
  output reg clkOut,
  output reg flashPower,
  output reg flashReady,
  output reg pinHold,
  output reg corePowerOff
);

////////////////////////////////////////////////////////////////////////////////
localparam [2:0] ST_BOOT = 3'h0;
localparam [2:0] ST_RUN = 3'h1;
localparam [2:0] ST_SLEEP = 3'h2;
localparam [2:0] ST_DSLEEP = 3'h3;
localparam [2:0] ST_PDOWN = 3'h4;
localparam [2:0] ST_DPD = 3'h5;
localparam [2:0] ST_WSTART = 3'h6;
localparam [2:0] ST_WRESUME = 3'h7;
localparam SW = NIRQ + 5;
localparam [31:0] PCLK_RST = `PM_PCLKEN_RST;
localparam [31:0] PDIV_RST = `PM_PDIV_RST;

function [31:0] mergeBytes;
  input [31:0] old;
  input [31:0] din;
  input [3:0] sel;
  integer i;
  begin
    mergeBytes = old;
    for (i = 0; i < 4; i = i + 1) begin
      if (sel[i]) begin
        mergeBytes[8*i +: 8] = din[8*i +: 8];
      end
    end
  end
endfunction

function [2:0] divMask;
  input [1:0] code;
  begin
    case (code)
      2'h0: divMask = 3'h0;
      2'h1: divMask = 3'h1;
      2'h2: divMask = 3'h3;
      default: divMask = 3'h7;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// synchronisers for pins and foreign levels
reg [SW-1:0] syncA;
reg [SW-1:0] syncB;
always @(posedge sys_clk or negedge arst_n) begin
  if (!arst_n) begin
    syncA <= {SW{1'b0}};
    syncB <= {SW{1'b0}};
  end else begin
    syncA <= {irqIn, rtcDpdReq, rtcAlarm, mainOscStable, mainOscLvl, rtcLvl};
    syncB <= syncA;
  end
end
wire [NIRQ-1:0] irqS = syncB[SW-1:5];
wire dpdReqS = syncB[4];
wire alarmS = syncB[3];
wire oscStableS = syncB[2];
wire mainLvlS = syncB[1];
wire rtcLvlS = syncB[0];

////////////////////////////////////////////////////////////////////////////////
// registers
reg [31:0] modeReg;
reg [2:0] coSel;
reg [7:0] cpuDiv;
reg [7:0] usbDiv;
reg [NPER-1:0] pclkPend;
reg [NPER-1:0] pclkAct;
reg [2*NPER-1:0] pdiv;
reg [NIRQ-1:0] wakeMask;
reg [2:0] state;
reg [2:0] next_state;
reg [12:0] wakeCnt;
reg [12:0] resumeTarget;
reg [12:0] oscTimer;
reg [12:0] flashCnt;
reg mainOscReady;
reg prevMain;

wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wrEn = busReq & wb_we_i;
wire [1:0] modeReq = modeReg[`PM_REQ_LSB +: 2];
wire enterLow = (state == ST_RUN) & cpuSleepReq;
wire enterDeep = enterLow & (modeReq != `PM_REQ_SLEEP);
wire enterPd = enterLow & (modeReq == `PM_REQ_PDOWN);
wire wakeHit = |(irqS & wakeMask);
wire [31:0] wrMode = mergeBytes(modeReg, wb_dat_i, wb_sel_i);
wire [31:0] wrDiv = mergeBytes({16'h0000, usbDiv, cpuDiv}, wb_dat_i, wb_sel_i);
wire [31:0] wrCo = mergeBytes({29'h0, coSel}, wb_dat_i, wb_sel_i);
wire [31:0] wrPclk = mergeBytes({{(32-NPER){1'b0}}, pclkPend}, wb_dat_i, wb_sel_i);
wire [31:0] wrPdiv = mergeBytes({{(32-2*NPER){1'b0}}, pdiv}, wb_dat_i, wb_sel_i);

always @(posedge sys_clk or negedge arst_n) begin
  if (!arst_n) begin
    modeReg <= `PM_MODE_RST;
    coSel <= `PM_CLKOUT_RST;
    cpuDiv <= `PM_DIV_RST;
    usbDiv <= `PM_DIV_RST;
    pclkPend <= PCLK_RST[NPER-1:0];
    pdiv <= PDIV_RST[2*NPER-1:0];
  end else begin
    if (wrEn && wb_adr_i == `PM_OFF_MODE) begin
      modeReg <= wrMode & `PM_MODE_MASK;
    end
    if (wrEn && wb_adr_i == `PM_OFF_CLKOUT) begin
      coSel <= wrCo[2:0];
    end
    if (wrEn && wb_adr_i == `PM_OFF_DIV) begin
      cpuDiv <= wrDiv[7:0];
      usbDiv <= wrDiv[15:8];
    end
    if (wrEn && wb_adr_i == `PM_OFF_PCLKEN) begin
      pclkPend <= wrPclk[NPER-1:0];
    end
    if (wrEn && wb_adr_i == `PM_OFF_PDIV) begin
      pdiv <= wrPdiv[2*NPER-1:0];
    end
    if (enterDeep) begin
      modeReg[`PM_MSYN_BIT] <= 1'b0; // RULE11
      modeReg[`PM_MCON_BIT] <= 1'b0; // RULE11
      cpuDiv <= 8'h00; // RULE11
      usbDiv <= 8'h00; // RULE11
    end
    if (enterPd) begin
      modeReg[`PM_CPUMAIN_BIT] <= 1'b0; // RULE5
    end
  end
end

// bus answer: one wait state, unmapped reads zero
always @(posedge sys_clk or negedge arst_n) begin
  if (!arst_n) begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h00000000;
  end else begin
    wb_ack_o <= busReq;
    if (busReq && !wb_we_i) begin
      case (wb_adr_i)
        `PM_OFF_MODE: wb_dat_o <= modeReg;
        `PM_OFF_CLKOUT: wb_dat_o <= {29'h0, coSel};
        `PM_OFF_DIV: wb_dat_o <= {16'h0000, usbDiv, cpuDiv};
        `PM_OFF_PCLKEN: wb_dat_o <= {{(32-NPER){1'b0}}, pclkPend};
        `PM_OFF_PDIV: wb_dat_o <= {{(32-2*NPER){1'b0}}, pdiv};
        `PM_OFF_STATUS: wb_dat_o <= {22'h0, flashReady, mainOscReady,
          usbFromSynth, cpuRun, {NIRQ{1'b0}} == wakeMask, prevMain, 1'b0, state};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// mode sequencing
always @* begin
  next_state = state;
  case (state)
    ST_BOOT: begin
      if (wakeCnt >= IRC_RESUME - 13'h1) begin
        next_state = ST_RUN; // RULE7
      end
    end
    ST_RUN: begin
      if (dpdReqS) begin
        next_state = ST_DPD; // RULE17
      end else if (cpuSleepReq) begin
        case (modeReq) // RULE22
          `PM_REQ_SLEEP: next_state = ST_SLEEP;
          `PM_REQ_DSLEEP: next_state = ST_DSLEEP;
          default: next_state = ST_PDOWN;
        endcase
      end
    end
    ST_SLEEP: begin
      if (|irqS) begin
        next_state = ST_RUN; // RULE8
      end
    end
    ST_DSLEEP: begin
      if (wakeHit) begin
        next_state = ST_WRESUME; // RULE20
      end
    end
    ST_PDOWN: begin
      if (wakeHit) begin
        next_state = ST_WSTART; // RULE20
      end
    end
    ST_DPD: begin
      if (alarmS) begin
        next_state = ST_WSTART; // RULE18
      end
    end
    ST_WSTART: begin
      if (wakeCnt >= IRC_START - 13'h1) begin
        next_state = ST_WRESUME; // RULE15
      end
    end
    ST_WRESUME: begin
      if (wakeCnt >= resumeTarget - 13'h1) begin
        next_state = ST_RUN; // RULE13
      end
    end
    default: next_state = ST_BOOT;
  endcase
end

always @(posedge sys_clk or negedge arst_n) begin
  if (!arst_n) begin
    state <= ST_BOOT;
    wakeCnt <= 13'h0000;
    resumeTarget <= 13'h0004;
    prevMain <= 1'b0;
    wakeMask <= {NIRQ{1'b0}};
    pclkAct <= PCLK_RST[NPER-1:0];
  end else begin
    state <= next_state;
    if (state != next_state) begin
      wakeCnt <= 13'h0000;
    end else begin
      wakeCnt <= wakeCnt + 13'h0001;
    end
    if (enterLow) begin
      pclkAct <= pclkPend; // RULE22
      wakeMask <= wakeMaskIn; // RULE19
      prevMain <= modeReg[`PM_CPUMAIN_BIT];
    end
    if (state == ST_DSLEEP) begin
      resumeTarget <= prevMain ? OSC_RESUME : IRC_RESUME; // RULE13
    end else if (state == ST_WSTART) begin
      resumeTarget <= IRC_RESUME; // RULE15
    end
  end
end

// main oscillator wake-up timer and flash start-up counter
always @(posedge sys_clk or negedge arst_n) begin
  if (!arst_n) begin
    oscTimer <= 13'h0000;
    mainOscReady <= 1'b0;
    flashCnt <= FLASH_START;
  end else begin
    if (!mainOscEn || !oscStableS) begin
      oscTimer <= 13'h0000; // RULE7
      mainOscReady <= 1'b0;
    end else if (oscTimer >= OSC_RESUME - 13'h1) begin
      mainOscReady <= 1'b1; // RULE7
    end else begin
      oscTimer <= oscTimer + 13'h0001;
    end
    if (state == ST_PDOWN || state == ST_DPD) begin
      flashCnt <= FLASH_START; // RULE16
    end else if (flashCnt != 13'h0000) begin
      flashCnt <= flashCnt - 13'h0001; // RULE16
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// clock generation and gating
reg [7:0] cpuDivCnt;
reg cpuPhase;
reg ircPhase;
reg [12:0] usbCnt;
reg [2:0] presc;
reg [NPER-1:0] tickNext;
integer p;
wire runLike = (next_state == ST_RUN);
wire deepLike = (next_state == ST_DSLEEP) | (next_state == ST_PDOWN) |
  (next_state == ST_DPD);
wire usbSynthOn = modeReg[`PM_USBSYN_BIT] & mainOscReady & mainOscEn & ~deepLike; // RULE2
reg coNext;

always @* begin
  case (coSel) // RULE4
    `PM_CO_CPU: coNext = cpuPhase;
    `PM_CO_IRC: coNext = ircPhase;
    `PM_CO_MAIN: coNext = mainLvlS;
    `PM_CO_RTC: coNext = rtcLvlS;
    `PM_CO_USB: coNext = usbClk;
    default: coNext = 1'b0;
  endcase
end

always @(posedge sys_clk or negedge arst_n) begin
  if (!arst_n) begin
    cpuDivCnt <= 8'h00;
    cpuPhase <= 1'b0;
    ircPhase <= 1'b0;
    usbCnt <= 13'h0000;
    usbClk <= 1'b0;
    presc <= 3'h0;
    clkOut <= 1'b0;
    periphTick <= {NPER{1'b0}};
  end else begin
    ircPhase <= ircOutEn ? ~ircPhase : 1'b0;
    if (!cpuClkEn) begin
      cpuDivCnt <= 8'h00;
    end else if (cpuDivCnt >= cpuDiv) begin
      cpuDivCnt <= 8'h00;
      cpuPhase <= ~cpuPhase;
    end else begin
      cpuDivCnt <= cpuDivCnt + 8'h01;
    end
    if (!usbSynthOn) begin
      usbCnt <= 13'h0000; // RULE1
      usbClk <= 1'b0;
    end else if (usbCnt >= `PM_USB_HALF_CYC - 1) begin
      usbCnt <= 13'h0000; // RULE3
      usbClk <= ~usbClk; // RULE3
    end else begin
      usbCnt <= usbCnt + 13'h0001;
    end
    clkOut <= coNext;
    presc <= deepLike ? 3'h0 : presc + 3'h1;
    periphTick <= periphClkEn & tickNext; // RULE21
  end
end

always @* begin
  tickNext = {NPER{1'b0}};
  for (p = 0; p < NPER; p = p + 1) begin
    tickNext[p] = ((presc & divMask(pdiv[2*p +: 2])) == 3'h0); // RULE21
  end
end

////////////////////////////////////////////////////////////////////////////////
// power and clock control outputs
always @(posedge sys_clk or negedge arst_n) begin
  if (!arst_n) begin
    cpuClkEn <= 1'b0;
    cpuRun <= 1'b0;
    periphClkEn <= {NPER{1'b0}};
    ircPower <= 1'b1;
    ircOutEn <= 1'b1;
    rtcOscEn <= 1'b1;
    mainOscEn <= 1'b0;
    mainSynthEn <= 1'b0;
    mainSynthConnect <= 1'b0;
    usbSynthPower <= 1'b0;
    usbSynthRef <= 1'b0;
    usbFromSynth <= 1'b0;
    flashPower <= 1'b1;
    flashReady <= 1'b0;
    pinHold <= 1'b0;
    corePowerOff <= 1'b0;
  end else begin
    cpuClkEn <= runLike; // RULE8
    cpuRun <= runLike; // RULE7
    periphClkEn <= deepLike ? {NPER{1'b0}} : pclkAct; // RULE9
    ircPower <= ~((next_state == ST_PDOWN) | (next_state == ST_DPD)); // RULE14
    ircOutEn <= ~deepLike; // RULE10
    rtcOscEn <= 1'b1; // RULE10
    mainOscEn <= modeReg[`PM_OSCEN_BIT] & ~deepLike; // RULE9
    mainSynthEn <= modeReg[`PM_MSYN_BIT] & ~deepLike; // RULE11
    mainSynthConnect <= modeReg[`PM_MCON_BIT] & ~deepLike; // RULE11
    usbSynthPower <= modeReg[`PM_USBSYN_BIT] & ~deepLike; // RULE1
    usbSynthRef <= modeReg[`PM_USBSYN_BIT] & mainOscEn & ~deepLike; // RULE2
    usbFromSynth <= usbSynthOn; // RULE1
    flashPower <= (next_state == ST_DSLEEP) | ~deepLike; // RULE12
    flashReady <= (flashCnt == 13'h0000) & ~deepLike; // RULE16
    pinHold <= deepLike; // RULE9
    corePowerOff <= (next_state == ST_DPD); // RULE17
  end
end

endmodule

// >>> bench/clock_source_model.sv
// oscillator and rtc clock sources facing the sequencer
`timescale 1ns/100ps
module clock_source_model (
  input wire sys_clk,
  input wire mainOscEn,
  input wire rtcOscEn,
  output logic mainOscStable = 1'h0,
  output logic mainOscLvl = 1'h0,
  output logic rtcLvl = 1'h0
);
  int oscAge = 0;
  logic [2:0] rtcAge = 3'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // crystal reports stable only after a start-up span
  always @(posedge sys_clk) begin
    if (!mainOscEn) begin
      oscAge <= 0;
      mainOscStable <= 1'h0;
    end else begin
      oscAge <= oscAge + 1;
      mainOscStable <= (oscAge >= 10);
      mainOscLvl <= !mainOscLvl;
    end
  end
  // rtc oscillator keeps running while enabled
  always @(posedge sys_clk) begin
    if (rtcOscEn) begin
      rtcAge <= rtcAge + 3'h1;
      if (rtcAge == 3'h7) begin
        rtcLvl <= !rtcLvl;
      end
    end
  end
endmodule

// >>> bench/pmws_monitor.sv
// port assertions for the power sequencer
`timescale 1ns/100ps
module pmws_monitor (
  input wire sys_clk,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire cpuSleepReq,
  input wire rtcAlarm,
  input wire cpuRun,
  input wire cpuClkEn,
  input wire pinHold,
  input wire mainSynthConnect,
  input wire rtcOscEn,
  input wire flashPower,
  input wire flashReady,
  input wire ircPower,
  input wire usbSynthPower,
  input wire usbSynthRef,
  input wire usbFromSynth,
  input wire corePowerOff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  sequence entrySeq;
    cpuRun && cpuSleepReq;
  endsequence
  sequence stoppedSeq;
    !cpuRun && !cpuClkEn;
  endsequence
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acked");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  sleep_entry_a: assert property (entrySeq |=> stoppedSeq)
    else $error("core clock kept after entry");
  hold_state_a: assert property (pinHold |-> !cpuClkEn && !mainSynthConnect)
    else $error("clocks alive while pins held");
  rtc_running_a: assert property (rtcOscEn)
    else $error("rtc oscillator stopped");
  flash_block_a: assert property ($rose(flashPower) |-> !flashReady [*8])
    else $error("flash ready too early");
  pdown_power_a: assert property (!ircPower |-> !flashPower)
    else $error("flash powered with rc off");
  usb_source_a: assert property (usbFromSynth |-> usbSynthPower && usbSynthRef)
    else $error("usb clock from unpowered synth");
  dpd_power_a: assert property (corePowerOff |-> !ircPower && !flashPower && rtcOscEn)
    else $error("power left on in deep power-down");
  dpd_stay_a: assert property (corePowerOff && !rtcAlarm |=> corePowerOff)
    else $error("deep power-down left without alarm");
  boot_wait_a: assert property ($rose(arst_n) |-> !cpuRun [*3])
    else $error("execution before wake-up timer");
endmodule
bind power_mode_wake_sequencer pmws_monitor pmws_monitor_inst (.sys_clk, .arst_n, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .cpuSleepReq, .rtcAlarm, .cpuRun, .cpuClkEn, .pinHold, .mainSynthConnect,
  .rtcOscEn, .flashPower, .flashReady, .ircPower, .usbSynthPower, .usbSynthRef, .usbFromSynth,
  .corePowerOff);

// >>> bench/power_mode_wake_sequencer_tb.sv
// self-checking bench of the power sequencer
`timescale 1ns/100ps
`include "pm_map.vh"
module power_mode_wake_sequencer_tb;
  localparam int IRCS = 20;
  localparam int OSCR = 16;
  localparam int IRCR = 4;
  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  logic wbCyc = 1'h0;
  logic wbStb = 1'h0;
  logic wbWe = 1'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbWdat = 32'h0;
  logic cpuSleepReq = 1'h0;
  logic [7:0] irqIn = 8'h00;
  logic [7:0] wakeMaskIn = 8'h00;
  logic rtcDpdReq = 1'h0;
  logic rtcAlarm = 1'h0;
  wire [31:0] wbRdat;
  wire [7:0] periphClkEn, periphTick;
  wire wbAck, mainOscStable, mainOscLvl, rtcLvl, cpuClkEn, cpuRun, ircPower, ircOutEn;
  wire rtcOscEn, mainOscEn, mainSynthConnect, usbSynthPower, usbFromSynth;
  wire flashPower, flashReady, pinHold, corePowerOff, usbClk, clkOut;
  int errors = 0;
  int totalChecks = 0;
  always #12.5 sys_clk = ~sys_clk;
  power_mode_wake_sequencer #(.IRC_START(13'h14), .FLASH_START(13'h28), .OSC_RESUME(13'h10))
    power_mode_wake_sequencer_inst (.sys_clk, .arst_n, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbWdat), .wb_dat_o(wbRdat),
    .wb_ack_o(wbAck), .cpuSleepReq, .irqIn, .wakeMaskIn, .rtcDpdReq, .rtcAlarm, .mainOscStable,
    .mainOscLvl, .rtcLvl, .cpuClkEn, .cpuRun, .periphClkEn, .periphTick, .ircPower, .ircOutEn,
    .rtcOscEn, .mainOscEn, .mainSynthEn(), .mainSynthConnect, .usbSynthPower, .usbSynthRef(),
    .usbFromSynth, .usbClk, .clkOut, .flashPower, .flashReady, .pinHold, .corePowerOff);
  clock_source_model clock_source_model_inst (.sys_clk, .mainOscEn, .rtcOscEn, .mainOscStable,
    .mainOscLvl, .rtcLvl);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wbXfer(input logic [7:0] a, input logic we, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge sys_clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= a;
    wbWdat <= d;
    do begin
      @(posedge sys_clk);
    end while (wbAck !== 1'h1);
    q = wbRdat;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbXfer(a, 1'h1, d, q);
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wbXfer(a, 1'h0, 32'h0, q);
    check(what, q, exp);
  endtask
  task automatic waitRun(output int n);
    n = 0;
    while (cpuRun !== 1'h1) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic pulseSleep;
    @(posedge sys_clk);
    cpuSleepReq <= 1'h1;
    @(posedge sys_clk);
    cpuSleepReq <= 1'h0;
    repeat (3) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    int n;
    waitRun(n);
    check("boot wait", n >= IRCR, 1'h1);
    check("usb synth power", usbSynthPower, 1'h0);
    check("usb from synth", usbFromSynth, 1'h0);
    check("rc output", ircOutEn, 1'h1);
    rdChk("mode reset", `PM_OFF_MODE, `PM_MODE_RST);
    rdChk("unmapped read", 8'h40, 32'h0);
    for (int s = 0; s < 5; s++) begin
      wr(`PM_OFF_CLKOUT, s);
      rdChk("clock out select", `PM_OFF_CLKOUT, s);
    end
  endtask
  task automatic t_sleep;
    int n;
    wr(`PM_OFF_MODE, 32'h0);
    wr(`PM_OFF_PCLKEN, 32'h0000000f);
    pulseSleep;
    check("core clock", cpuClkEn, 1'h0);
    check("periph clocks", periphClkEn, 8'h0f);
    irqIn <= 8'h20;
    waitRun(n);
    check("sleep wake", cpuClkEn, 1'h1);
    irqIn <= 8'h00;
  endtask
  task automatic t_pdiv;
    int t0, t1, t4;
    wr(`PM_OFF_PDIV, 32'h00000003);
    t0 = 0;
    t1 = 0;
    t4 = 0;
    repeat (64) begin
      @(posedge sys_clk);
      t0 += periphTick[0];
      t1 += periphTick[1];
      t4 += periphTick[4];
    end
    check("tick every 8", t0, 8);
    check("tick every 1", t1, 64);
    check("gated tick", t4, 0);
  endtask
  task automatic t_usb;
    int hi, co;
    logic [31:0] q;
    wr(`PM_OFF_MODE, 32'h0000000c);
    do begin
      wbXfer(`PM_OFF_STATUS, 1'h0, 32'h0, q);
    end while (q[7] !== 1'h1);
    check("usb from synth on", usbFromSynth, 1'h1);
    hi = 0;
    co = 0;
    repeat (16) begin
      @(posedge sys_clk);
      hi += usbClk;
      co += clkOut;
    end
    check("usb duty", hi, 8);
    check("clock out usb", co, 8);
  endtask
  task automatic t_deep(input logic [31:0] mode, input int expMin);
    int n;
    logic [31:0] q;
    wr(`PM_OFF_MODE, 32'h00000008);
    do begin
      wbXfer(`PM_OFF_STATUS, 1'h0, 32'h0, q);
    end while (q[8] !== 1'h1);
    wr(`PM_OFF_MODE, mode);
    wr(`PM_OFF_DIV, 32'h00000302);
    wakeMaskIn <= 8'h02;
    pulseSleep;
    check("pins held", pinHold, 1'h1);
    check("synth connect", mainSynthConnect, 1'h0);
    check("rc output", ircOutEn, 1'h0);
    check("rc power", ircPower, 1'h1);
    check("flash power", flashPower, 1'h1);
    irqIn <= 8'h01;
    repeat (20) @(posedge sys_clk);
    check("masked irq", cpuRun, 1'h0);
    irqIn <= 8'h03;
    waitRun(n);
    check("resume count", n >= expMin && n <= expMin + 8, 1'h1);
    irqIn <= 8'h00;
    rdChk("div cleared", `PM_OFF_DIV, 32'h0);
    rdChk("synth bits cleared", `PM_OFF_MODE, mode & 32'hffffff9f);
  endtask
  task automatic t_pdown;
    int n;
    wr(`PM_OFF_MODE, 32'h00000002);
    wakeMaskIn <= 8'h04;
    pulseSleep;
    check("rc off", ircPower, 1'h0);
    check("flash off", flashPower, 1'h0);
    irqIn <= 8'h04;
    waitRun(n);
    check("rc start", n >= IRCS + IRCR, 1'h1);
    check("flash blocked", flashReady, 1'h0);
    check("rc running", ircOutEn, 1'h1);
    irqIn <= 8'h00;
    repeat (40) @(posedge sys_clk);
    check("flash ready", flashReady, 1'h1);
  endtask
  task automatic t_dpd;
    int n;
    rtcDpdReq <= 1'h1;
    repeat (6) @(posedge sys_clk);
    rtcDpdReq <= 1'h0;
    check("dpd entered", corePowerOff, 1'h1);
    irqIn <= 8'hff;
    repeat (20) @(posedge sys_clk);
    check("irq ignored", corePowerOff, 1'h1);
    irqIn <= 8'h00;
    rtcAlarm <= 1'h1;
    waitRun(n);
    rtcAlarm <= 1'h0;
    check("dpd wake", corePowerOff, 1'h0);
    check("rc start", n >= IRCS + IRCR, 1'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'h1;
    t_reset;
    t_sleep;
    t_pdiv;
    t_usb;
    t_deep(32'h00000079, OSCR);
    t_deep(32'h00000001, IRCR);
    t_pdown;
    t_dpd;
    tally_and_finish;
  end
  initial begin
    #2000000;
    errors++;
    tally_and_finish;
  end
endmodule
